/* shared/pbk_defines.vh */
// constants for the parkbrake control and fault detect block
`ifndef PBK_DEFINES_VH
`define PBK_DEFINES_VH
// flash codes reported on faults
`define PBK_FLASH_NONE 4'h0
`define PBK_FLASH_LEFT 4'h5
`define PBK_FLASH_RIGHT 4'h6
// brake configuration selector values
`define PBK_CFG_SINGLE 1'b0
`define PBK_CFG_DUAL 1'b1
// default zero demand brake delay in ms, and in cycles at 100 MHz
`define PBK_DELAY_MS 500
`define PBK_HOLD_MS 200
`define PBK_CLK_MHZ 100
`define PBK_DELAY_CYC (`PBK_DELAY_MS * 1000 * `PBK_CLK_MHZ)
`define PBK_HOLD_CYC (`PBK_HOLD_MS * 1000 * `PBK_CLK_MHZ)
// settle time of the presence test in us, and in cycles
`define PBK_TEST_US 100
`define PBK_TEST_CYC (`PBK_TEST_US * `PBK_CLK_MHZ)
// timer width
`define PBK_TW 32
`endif

/* design/pbk_sync.v */
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module pbk_sync
#(
  parameter W = 1
)
(
  input wire I_CLOCK,
  input wire I_RST_B,
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_q; // first stage, read only by second
  reg [W-1:0] sync_q; // second stage
  // two stages toward the clock domain
  always @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  assign o_sync = sync_q;
endmodule

/* design/pbk_ctrl.v */
// parkbrake release sequencing and brake presence fault detection
`timescale 1ns/1ps
// Function
// [RL1] brakes de-energised unless release is intended
// [RL2] missing brake raises fault and blocks driving
// [RL3] dual: each brake from its own output
// [RL4] single: left output only, right unused
// [RL5] single, no left load: flash code 5
// [RL6] dual, no right load: flash code 6; code gives 5 instead when the left load is missing too
// [RL7] series brakes fed from left positive terminal
// [RL8] wait zero demand delay before applying brakes
// [RL9] motor hold time, then bridges off
// [RL10] test presence before release, latch faults
`include "pbk_defines.vh"
module pbk_ctrl
#(
  parameter [`PBK_TW-1:0] DELAY_CYC = `PBK_DELAY_CYC,
  parameter [`PBK_TW-1:0] HOLD_CYC = `PBK_HOLD_CYC,
  parameter [`PBK_TW-1:0] TEST_CYC = `PBK_TEST_CYC
)
(
  input wire I_CLOCK,
  input wire I_RST_B,
  input wire I_BRAKE_DUAL,
  input wire I_DEMAND_NONZERO,
  input wire I_LEFT_LOAD,
  input wire I_RIGHT_LOAD,
  input wire I_FAULT_CLEAR,
  input wire [`PBK_TW-1:0] I_DELAY_CYC,
  input wire [`PBK_TW-1:0] I_HOLD_CYC,
  input wire I_USE_PROG,
  output reg O_LEFT_BRAKE_DRIVE,
  output reg O_RIGHT_BRAKE_DRIVE,
  output reg O_LEFT_TEST,
  output reg O_RIGHT_TEST,
  output reg O_BRIDGE_ON,
  output reg O_MOTOR_HOLD,
  output reg O_DRIVE_ENABLE,
  output reg O_LEFT_FAULT,
  output reg O_RIGHT_FAULT,
  output reg [3:0] O_FLASH_CODE
);
  ////////////////////////////////////////////////////////////////////////////
  // states, one-hot
  localparam [4:0] ST_IDLE = 5'h01; // brakes applied, bridge off
  localparam [4:0] ST_TEST = 5'h02; // presence test on outputs
  localparam [4:0] ST_DRIVE = 5'h04; // brakes released, driving
  localparam [4:0] ST_DELAY = 5'h08; // zero demand, still released
  localparam [4:0] ST_HOLD = 5'h10; // brakes off, motors hold
  reg [4:0] state_q; // current state
  reg [4:0] state_d; // next state
  reg [`PBK_TW-1:0] tmr_q; // cycle timer
  reg [`PBK_TW-1:0] tmr_d; // next timer
  localparam [`PBK_TW-1:0] TMR_ONE = {{(`PBK_TW-1){1'b0}}, 1'b1}; // timer step at full width
  reg lflt_q; // latched left fault
  reg rflt_q; // latched right fault
  reg lflt_d;
  reg rflt_d;
  wire dual; // synced config selector
  wire demand; // synced nonzero demand
  wire lload; // synced left load sense
  wire rload; // synced right load sense
  wire fclr; // synced fault clear
  wire [`PBK_TW-1:0] delay_lim; // chosen delay count
  wire [`PBK_TW-1:0] hold_lim; // chosen hold count
  wire any_fault; // any latched fault
  wire test_l; // left fault seen this test
  wire test_r; // right fault seen this test
  ////////////////////////////////////////////////////////////////////////////
  // pin inputs through two flip-flops
  pbk_sync #(.W(5)) u_sync
  (
    .I_CLOCK(I_CLOCK),
    .I_RST_B(I_RST_B),
    .i_async({I_BRAKE_DUAL, I_DEMAND_NONZERO, I_LEFT_LOAD, I_RIGHT_LOAD, I_FAULT_CLEAR}),
    .o_sync({dual, demand, lload, rload, fclr})
  );
  // programmable times or defaults
  assign delay_lim = I_USE_PROG ? I_DELAY_CYC : DELAY_CYC;
  assign hold_lim = I_USE_PROG ? I_HOLD_CYC : HOLD_CYC;
  assign any_fault = lflt_q | rflt_q;
  // left checked in both configs, right only in dual
  assign test_l = !lload; // see [RL5]
  assign test_r = (dual == `PBK_CFG_DUAL) && !rload; // see [RL6]
  ////////////////////////////////////////////////////////////////////////////
  // next state, timer and fault latches
  always @*
  begin
    state_d = state_q;
    tmr_d = tmr_q;
    lflt_d = lflt_q;
    rflt_d = rflt_q;
    // clear drops the latched faults only while in ST_IDLE
    if (fclr && state_q == ST_IDLE)
    begin
      lflt_d = 1'b0;
      rflt_d = 1'b0;
    end
    case (state_q)
      ST_IDLE:
      begin
        tmr_d = {`PBK_TW{1'b0}};
        // test before any release
        if (demand && !any_fault)
          state_d = ST_TEST; // see [RL10]
      end
      ST_TEST:
      begin
        tmr_d = tmr_q + TMR_ONE;
        if (tmr_q >= TEST_CYC - TMR_ONE)
        begin
          tmr_d = {`PBK_TW{1'b0}};
          lflt_d = lflt_q | test_l; // see [RL10]
          rflt_d = rflt_q | test_r; // see [RL10]
          if (test_l || test_r)
            state_d = ST_IDLE; // see [RL2]
          else
            state_d = ST_DRIVE;
        end
      end
      ST_DRIVE:
      begin
        tmr_d = {`PBK_TW{1'b0}};
        // open circuit while driving
        if (test_l || test_r)
        begin
          lflt_d = lflt_q | test_l; // see [RL2]
          rflt_d = rflt_q | test_r; // see [RL2]
          state_d = ST_HOLD;
        end
        else if (!demand)
          state_d = ST_DELAY;
      end
      ST_DELAY:
      begin
        tmr_d = tmr_q + TMR_ONE;
        if (demand)
          state_d = ST_DRIVE; // see [RL8]
        else if (tmr_q >= delay_lim)
        begin
          tmr_d = {`PBK_TW{1'b0}};
          state_d = ST_HOLD; // see [RL8]
        end
      end
      ST_HOLD:
      begin
        tmr_d = tmr_q + TMR_ONE;
        if (tmr_q >= hold_lim)
        begin
          tmr_d = {`PBK_TW{1'b0}};
          state_d = ST_IDLE; // see [RL9]
        end
      end
      default:
      begin
        state_d = ST_IDLE;
        tmr_d = {`PBK_TW{1'b0}};
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // state registers
  always @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      state_q <= ST_IDLE;
      tmr_q <= {`PBK_TW{1'b0}};
      lflt_q <= 1'b0;
      rflt_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      lflt_q <= lflt_d;
      rflt_q <= rflt_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_LEFT_BRAKE_DRIVE <= 1'b0;
      O_RIGHT_BRAKE_DRIVE <= 1'b0;
      O_LEFT_TEST <= 1'b0;
      O_RIGHT_TEST <= 1'b0;
      O_BRIDGE_ON <= 1'b0;
      O_MOTOR_HOLD <= 1'b0;
      O_DRIVE_ENABLE <= 1'b0;
      O_LEFT_FAULT <= 1'b0;
      O_RIGHT_FAULT <= 1'b0;
      O_FLASH_CODE <= `PBK_FLASH_NONE;
    end
    else
    begin
      // energise only in released states
      O_LEFT_BRAKE_DRIVE <= (state_d == ST_DRIVE) || (state_d == ST_DELAY); // see [RL1] [RL3] [RL4] [RL7]
      // right output used only in dual config
      O_RIGHT_BRAKE_DRIVE <= ((state_d == ST_DRIVE) || (state_d == ST_DELAY))
        && (dual == `PBK_CFG_DUAL); // see [RL1] [RL3] [RL4]
      // sense current on the enabled outputs
      O_LEFT_TEST <= (state_d == ST_TEST); // see [RL10]
      O_RIGHT_TEST <= (state_d == ST_TEST) && (dual == `PBK_CFG_DUAL); // see [RL10]
      O_BRIDGE_ON <= (state_d == ST_DRIVE) || (state_d == ST_DELAY) || (state_d == ST_HOLD); // see [RL9]
      O_MOTOR_HOLD <= (state_d == ST_HOLD); // see [RL9]
      // driving blocked while any fault latched
      O_DRIVE_ENABLE <= (state_d == ST_DRIVE) && !(lflt_d | rflt_d); // see [RL2]
      O_LEFT_FAULT <= lflt_d;
      O_RIGHT_FAULT <= rflt_d;
      // left fault takes priority in the flash code
      if (lflt_d)
        O_FLASH_CODE <= `PBK_FLASH_LEFT; // see [RL5]
      else if (rflt_d)
        O_FLASH_CODE <= `PBK_FLASH_RIGHT; // see [RL6]
      else
        O_FLASH_CODE <= `PBK_FLASH_NONE;
    end
  end
endmodule

/* verification/pbk_ctrl_assertions.sv */
// port assertions for the parkbrake controller
`timescale 1ns/1ps
module pbk_ctrl_chk
(
  input wire I_CLOCK,
  input wire I_RST_B,
  input wire O_LEFT_BRAKE_DRIVE,
  input wire O_RIGHT_BRAKE_DRIVE,
  input wire O_LEFT_TEST,
  input wire O_BRIDGE_ON,
  input wire O_MOTOR_HOLD,
  input wire O_DRIVE_ENABLE,
  input wire O_LEFT_FAULT,
  input wire O_RIGHT_FAULT,
  input wire [3:0] O_FLASH_CODE
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_B);
  property p_rel; O_LEFT_BRAKE_DRIVE |-> !O_LEFT_FAULT && !O_RIGHT_FAULT; endproperty
  a_rel: assert property (p_rel) else $error("brake fed with fault");
  property p_blk; O_LEFT_FAULT || O_RIGHT_FAULT |-> !O_DRIVE_ENABLE; endproperty
  a_blk: assert property (p_blk) else $error("drive with fault");
  property p_pair; O_RIGHT_BRAKE_DRIVE |-> O_LEFT_BRAKE_DRIVE; endproperty
  a_pair: assert property (p_pair) else $error("right fed alone");
  property p_fl5; O_LEFT_FAULT |-> O_FLASH_CODE == 4'h5; endproperty
  a_fl5: assert property (p_fl5) else $error("left code");
  property p_fl6; O_RIGHT_FAULT && !O_LEFT_FAULT |-> O_FLASH_CODE == 4'h6; endproperty
  a_fl6: assert property (p_fl6) else $error("right code");
  property p_dly; $fell(O_DRIVE_ENABLE) && O_LEFT_BRAKE_DRIVE |-> O_LEFT_BRAKE_DRIVE [*8]; endproperty
  a_dly: assert property (p_dly) else $error("brake applied early");
  property p_hld; $rose(O_MOTOR_HOLD) |-> !O_LEFT_BRAKE_DRIVE && O_BRIDGE_ON ##1 O_MOTOR_HOLD [*8]; endproperty
  a_hld: assert property (p_hld) else $error("hold short");
  property p_off; $fell(O_MOTOR_HOLD) |-> !O_BRIDGE_ON; endproperty
  a_off: assert property (p_off) else $error("bridge left on");
  property p_tst; $rose(O_LEFT_BRAKE_DRIVE) |-> $past(O_LEFT_TEST); endproperty
  a_tst: assert property (p_tst) else $error("release untested");
endmodule
bind pbk_ctrl pbk_ctrl_chk pbk_ctrl_chk_i (.I_CLOCK, .I_RST_B, .O_LEFT_BRAKE_DRIVE, .O_RIGHT_BRAKE_DRIVE,
  .O_LEFT_TEST, .O_BRIDGE_ON, .O_MOTOR_HOLD, .O_DRIVE_ENABLE, .O_LEFT_FAULT, .O_RIGHT_FAULT, .O_FLASH_CODE);

/* verification/pbk_coil_model.sv */
// brake coil with continuity sense on one motor port
`timescale 1ns/1ps
module pbk_coil_model
(
  input wire i_drive,
  input wire i_test,
  input wire i_present,
  output wire o_load
);
  // current flows only in a fitted coil that is fed or tested
  assign o_load = i_present & (i_drive | i_test);
endmodule

/* verification/tb_pbk_ctrl.sv */
// self-checking bench for the parkbrake controller
`timescale 1ns/1ps
module tb_pbk_ctrl;
  reg clk = 0, rst_b = 0, dual = 0, dem = 0, lp = 0, rp = 0, clr = 0;
  reg [31:0] dly = 32'hC;
  // default times given to the design, used when not programmed
  localparam [31:0] DLY_DEF = 32'h14;
  localparam [31:0] HLD_DEF = 32'hA;
  reg prog = 0; // use programmed times
  reg [31:0] hold = 32'hA; // programmed hold time
  reg [31:0] dl; // expected delay count in force
  reg [31:0] hl; // expected hold count in force
  reg [3:0] cfg;
  reg [3:0] ef;
  wire lb, rb, lt, rt, br, mh, de, lf, rf, ll, rl;
  wire [3:0] fc;
  integer n_mismatch = 0, total_checks = 0, k;
  ////////////////////////////////////////////////////////////////
  pbk_ctrl #(.DELAY_CYC(DLY_DEF), .HOLD_CYC(HLD_DEF), .TEST_CYC(4)) pbk_ctrl_i (.I_CLOCK(clk), .I_RST_B(rst_b),
    .I_BRAKE_DUAL(dual), .I_DEMAND_NONZERO(dem), .I_LEFT_LOAD(ll), .I_RIGHT_LOAD(rl), .I_FAULT_CLEAR(clr),
    .I_DELAY_CYC(dly), .I_HOLD_CYC(hold), .I_USE_PROG(prog), .O_LEFT_BRAKE_DRIVE(lb),
    .O_RIGHT_BRAKE_DRIVE(rb), .O_LEFT_TEST(lt), .O_RIGHT_TEST(rt), .O_BRIDGE_ON(br), .O_MOTOR_HOLD(mh),
    .O_DRIVE_ENABLE(de), .O_LEFT_FAULT(lf), .O_RIGHT_FAULT(rf), .O_FLASH_CODE(fc));
  // index 0 left port, 1 right port
  pbk_coil_model pbk_coil_model_i [1:0] (.i_drive({rb, lb}), .i_test({rt, lt}), .i_present({rp, lp}),
    .o_load({rl, ll}));
  initial
  begin
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  // expected flash code, left port wins
  function [3:0] exp_flash(input d, input l, input r);
    exp_flash = !l ? 4'h5 : (d && !r) ? 4'h6 : 4'h0;
  endfunction
  task chk(input [63:0] nm, input [3:0] e, input [3:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e)
      begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // inputs move on falling edges only
  task wt(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task print_verdict;
    begin
      if (n_mismatch == 0 && total_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // hang guard
  initial
  begin
    #100000;
    n_mismatch = n_mismatch + 1;
    print_verdict;
  end
  initial
  begin
    k = $urandom(32'h852e);
    wt(20);
    rst_b = 1;
    wt(2);
    chk("reset", 4'h0, {lb, rb, br, de});
    for (k = 0; k < 12; k = k + 1)
    begin
      // corner configurations first, then random ones
      cfg = (k < 5) ? (20'h17362 >> (4 * k)) : $urandom;
      {dual, lp, rp} = cfg[2:0];
      // programmed or default times, both seen in the corners
      prog = k[1];
      dly = 32'hC + $urandom % 16;
      hold = 32'h8 + $urandom % 8;
      dl = prog ? dly : DLY_DEF;
      hl = prog ? hold : HLD_DEF;
      dem = 0;
      clr = 1;
      wt(16);
      clr = 0;
      wt(2);
      dem = 1;
      // presence test runs on the configured outputs
      wt(4);
      chk("test", {2'h0, dual, 1'b1}, {2'h0, rt, lt});
      wt(16);
      ef = exp_flash(dual, lp, rp);
      chk("flash", ef, fc);
      chk("faults", {2'h0, !lp, dual && !rp}, {2'h0, lf, rf});
      chk("brakes", {1'b0, ef == 0 && dual, ef == 0, ef == 0}, {1'b0, rb, lb, de});
      if (ef == 0 && k[0])
      begin
        // coil lost while driving
        lp = 0;
        wt(5);
        chk("lost", 4'h4, {1'b0, lf, de, lb});
      end
      else if (ef == 0)
      begin
        // demand back inside the delay
        dem = 0;
        wt(6);
        dem = 1;
        wt(6);
        chk("back", 4'h3, {2'h0, lb, de});
        // released for the whole delay of dl + 1 cycles, applied right after
        dem = 0;
        wt(dl + 3);
        chk("delay", 4'h2, {2'h0, lb, de});
        wt(1);
        chk("hold", 4'h3, {1'b0, lb, mh, br});
        // motors hold for hl + 1 cycles, then the bridge goes off
        wt(hl);
        chk("hold end", 4'h6, {lb, mh, br, de});
        wt(1);
        chk("off", 4'h0, {lb, mh, br, de});
      end
    end
    print_verdict;
  end
endmodule
